// ### design/msc_pkg.sv
package msc_pkg;
  localparam int CLK_HZ = 40_000_000;
  localparam int BAUD_MAX = 28_800;
  // Bit period at the fastest allowed rate, rounded up to whole cycles.
  localparam int BIT_CYC = (CLK_HZ + BAUD_MAX - 1) / BAUD_MAX;
  localparam int SEC_BYTES = 8;
  localparam int BRK_LOW_BITS = 9;
  localparam int BRK_GAP_BITS = 2;
  localparam int FRAME_BITS = 10;
  localparam int FIFO_DEPTH = 4;
  localparam int FIFO_W = 10;
  localparam logic [7:0] OP_WRITE = 8'h49;
  localparam logic [15:0] VEC_RESET_USER = 16'hfffe;
  localparam logic [15:0] VEC_RESET_MON = 16'hfefe;
  localparam logic [15:0] VEC_TRAP_USER = 16'hfffc;
  localparam logic [15:0] VEC_TRAP_MON = 16'hfefc;
  localparam logic [7:0] RESET_BYTE = 8'h00;
  localparam logic [15:0] RESET_ADDR = 16'h0000;
endpackage : msc_pkg

// ### design/msc_fifo.sv
`timescale 1ns/100ps
module msc_fifo #(
  parameter int W = 10,
  parameter int D = 4
) (
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic in_vld,
  output logic in_rdy,
  input wire logic [W-1:0] in_data,
  output logic out_vld,
  input wire logic out_rdy,
  output logic [W-1:0] out_data
);
  localparam int AW = $clog2(D);

  generate
    if (D < 2 || (1 << AW) != D) begin : g_bad_depth
      $error("Depth must be a power of two of at least two.");
    end
  endgenerate

  logic [W-1:0] mem_r [D];
  logic [AW:0] wp_r, wp_nxt, rp_r, rp_nxt;
  logic do_wr, do_rd;

  always_comb begin
    in_rdy = (wp_r[AW] == rp_r[AW]) || (wp_r[AW-1:0] != rp_r[AW-1:0]);
    out_vld = wp_r != rp_r;
    out_data = mem_r[rp_r[AW-1:0]];
    do_wr = in_vld && in_rdy;
    do_rd = out_vld && out_rdy;
    wp_nxt = do_wr ? wp_r + 1'b1 : wp_r;
    rp_nxt = do_rd ? rp_r + 1'b1 : rp_r;
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      wp_r <= '0;
      rp_r <= '0;
    end else begin
      wp_r <= wp_nxt;
      rp_r <= rp_nxt;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (do_wr) begin
      mem_r[wp_r[AW-1:0]] <= in_data;
    end
  end
endmodule : msc_fifo

// ### design/msc_port.sv
`timescale 1ns/100ps
// How it works
// R01: All traffic uses one wired-OR serial pin; other pins keep normal function.
// R02: Bytes travel in NRZ mark/space format on that single pin.
// R03: One bit divider serves receive and transmit, up to the maximum rate.
// R04: Monitor mode is entered by soft trap or by reset release with strap.
// R05: After reset entry, eight security bytes are taken before any command.
// R06: After the security bytes a ready break of zero bits is sent.
// R07: Monitor mode moves reset and trap vectors to the alternate page.
// R08: Watchdog off in monitor mode while high voltage present, else config bit.
// R09: Clock bypass pin low at monitor entry skips the oscillator divider.
// R10: Every received byte is echoed back at once.
// R11: Command results are sent only after the final byte's echo.
// R12: A break is a start bit plus nine more low bit periods.
// R13: A received break gets two high bit periods, then an echoed break.
// R14: Six commands: read, write, indexed read and write, stack read, run.
// R15: Write takes address high, low and data, stores the byte, returns nothing.
// R16: With read protection on, unauthorised access to protected memory is refused.
// R17: Indexed read returns the two bytes after the last accessed address.
// R18: A character is start bit, eight data bits LSB first, stop bit.
// R19: The host waits for each echo before sending its next byte.
module msc_port #(
  parameter int BAUD_DIV = msc_pkg::BIT_CYC,
  parameter logic [7:0] OP_READ = 8'h41,
  parameter logic [7:0] OP_IDX_READ = 8'h42,
  parameter logic [7:0] OP_IDX_WRITE = 8'h43,
  parameter logic [7:0] OP_SP_READ = 8'h44,
  parameter logic [7:0] OP_RUN = 8'h45
) (
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic serial_comm_pin_in,
  output logic serial_comm_pin_out,
  output logic serial_comm_pin_oe,
  input wire logic soft_trap_instruction,
  input wire logic high_test_voltage,
  input wire logic clock_bypass_select_pin,
  input wire logic watchdog_disable_bit,
  input wire logic read_protect_en,
  input wire logic sec_authorized,
  input wire logic mem_protected,
  input wire logic [15:0] stack_pointer,
  input wire logic [7:0] mem_rdata,
  output logic [15:0] mem_addr,
  output logic [7:0] mem_wdata,
  output logic mem_we,
  output logic mem_re,
  output logic run_pulse,
  output logic monitor_mode,
  output logic osc_div_bypass,
  output logic watchdog_enable,
  output logic [15:0] reset_vector_addr,
  output logic [15:0] trap_vector_addr
);
  import msc_pkg::*;

  localparam int CW = $clog2(BAUD_DIV + 1);
  localparam logic [CW-1:0] DIV_M1 = CW'(BAUD_DIV - 1);
  localparam logic [CW-1:0] DIV_HALF = CW'(BAUD_DIV / 2);

  generate
    if (BAUD_DIV < 4) begin : g_bad_div
      $error("Bit divider too small.");
    end
  endgenerate

  typedef enum {RX_IDLE, RX_BITS, RX_HOLD} msc_rx_e;
  typedef enum {TX_IDLE, TX_GAP, TX_BITS} msc_tx_e;
  typedef enum {S_SEC, S_RDY, S_CMD, S_AH, S_AL, S_DATA, S_WR, S_RQ, S_RW, S_RP, S_PSH,
                S_SPH, S_SPL, S_BRK} msc_st_e;

  // Receiver.
  msc_rx_e rx_st_r, rx_st_nxt;
  logic [CW-1:0] rx_cnt_r, rx_cnt_nxt;
  logic [3:0] rx_bit_r, rx_bit_nxt;
  logic [9:0] rx_sh_r, rx_sh_nxt;
  logic rx_vld_r, rx_vld_nxt, rx_brk_r, rx_brk_nxt;
  logic [7:0] rx_byte_r, rx_byte_nxt;
  logic rx_take, rx_en;
  logic [9:0] rx_new;

  // Transmitter and queue.
  msc_tx_e tx_st_r, tx_st_nxt;
  logic [CW-1:0] tx_cnt_r, tx_cnt_nxt;
  logic [3:0] tx_bit_r, tx_bit_nxt;
  logic [9:0] tx_sh_r, tx_sh_nxt;
  logic oe_r, oe_nxt;
  logic f_ivld, f_irdy, f_ovld, f_ordy;
  logic [FIFO_W-1:0] f_idata, f_odata;

  // Command sequencer.
  msc_st_e st_r, st_nxt;
  logic [3:0] sec_cnt_r, sec_cnt_nxt;
  logic [7:0] op_r, op_nxt, dat_r, dat_nxt;
  logic [15:0] ptr_r, ptr_nxt, addr_r, addr_nxt;
  logic [1:0] left_r, left_nxt;
  logic we_r, we_nxt, re_r, re_nxt, run_r, run_nxt;
  logic mon_r, mon_nxt, byp_r, byp_nxt, boot_r, wd_r, wd_nxt;
  logic deny;
  logic [15:0] rvec_r, rvec_nxt, tvec_r, tvec_nxt;

  msc_fifo #(.W(FIFO_W), .D(FIFO_DEPTH)) u_txq (
    .clk_sys(clk_sys),
    .rstn(rstn),
    .in_vld(f_ivld),
    .in_rdy(f_irdy),
    .in_data(f_idata),
    .out_vld(f_ovld),
    .out_rdy(f_ordy),
    .out_data(f_odata)
  );

  // Half duplex: listening only while nothing is queued or being sent.
  assign rx_en = (tx_st_r == TX_IDLE) && !f_ovld; // R01
  assign rx_new = {serial_comm_pin_in, rx_sh_r[9:1]};

  always_comb begin
    rx_st_nxt = rx_st_r;
    rx_cnt_nxt = rx_cnt_r;
    rx_bit_nxt = rx_bit_r;
    rx_sh_nxt = rx_sh_r;
    rx_vld_nxt = rx_vld_r && !rx_take;
    rx_brk_nxt = rx_brk_r;
    rx_byte_nxt = rx_byte_r;
    unique case (rx_st_r)
      RX_IDLE: begin
        if (rx_en && !serial_comm_pin_in) begin // R02
          rx_st_nxt = RX_BITS;
          rx_cnt_nxt = DIV_HALF;
          rx_bit_nxt = 4'h0;
        end
      end
      RX_BITS: begin
        if (rx_cnt_r != '0) begin
          rx_cnt_nxt = rx_cnt_r - 1'b1;
        end else begin
          rx_cnt_nxt = DIV_M1; // R03
          rx_sh_nxt = rx_new;
          rx_bit_nxt = rx_bit_r + 1'b1;
          if (rx_bit_r == 4'h0 && serial_comm_pin_in) begin
            rx_st_nxt = RX_IDLE;
          end else if (rx_bit_r == 4'(FRAME_BITS - 1)) begin
            if (rx_new[9]) begin // R18
              rx_st_nxt = RX_IDLE;
              rx_vld_nxt = 1'b1;
              rx_brk_nxt = 1'b0;
              rx_byte_nxt = rx_new[8:1];
            end else begin
              rx_st_nxt = RX_HOLD;
              if (rx_new[9:1] == '0) begin // R12
                rx_vld_nxt = 1'b1;
                rx_brk_nxt = 1'b1;
              end
            end
          end
        end
      end
      RX_HOLD: begin
        if (serial_comm_pin_in) begin
          rx_st_nxt = RX_IDLE;
        end
      end
    endcase
  end

  always_comb begin
    tx_st_nxt = tx_st_r;
    tx_cnt_nxt = tx_cnt_r;
    tx_bit_nxt = tx_bit_r;
    tx_sh_nxt = tx_sh_r;
    f_ordy = 1'b0;
    unique case (tx_st_r)
      TX_IDLE: begin
        if (f_ovld) begin
          f_ordy = 1'b1;
          tx_cnt_nxt = DIV_M1;
          tx_bit_nxt = 4'h0;
          if (f_odata[9]) begin
            tx_sh_nxt = '0; // R12
            tx_st_nxt = f_odata[8] ? TX_GAP : TX_BITS;
          end else begin
            tx_sh_nxt = {1'b1, f_odata[7:0], 1'b0}; // R18
            tx_st_nxt = TX_BITS;
          end
        end
      end
      TX_GAP: begin
        if (tx_cnt_r != '0) begin
          tx_cnt_nxt = tx_cnt_r - 1'b1;
        end else begin
          tx_cnt_nxt = DIV_M1;
          tx_bit_nxt = tx_bit_r + 1'b1;
          if (tx_bit_r == 4'(BRK_GAP_BITS - 1)) begin // R13
            tx_bit_nxt = 4'h0;
            tx_st_nxt = TX_BITS;
          end
        end
      end
      TX_BITS: begin
        if (tx_cnt_r != '0) begin
          tx_cnt_nxt = tx_cnt_r - 1'b1;
        end else begin
          tx_cnt_nxt = DIV_M1;
          tx_sh_nxt = {1'b1, tx_sh_r[9:1]};
          tx_bit_nxt = tx_bit_r + 1'b1;
          if (tx_bit_r == 4'(FRAME_BITS - 1)) begin
            tx_st_nxt = TX_IDLE;
          end
        end
      end
    endcase
    // The pin is only ever pulled low; the external pull-up makes the highs.
    oe_nxt = (tx_st_nxt == TX_BITS) && !tx_sh_nxt[0]; // R01
  end

  assign deny = read_protect_en && !sec_authorized && mem_protected; // R16

  always_comb begin
    st_nxt = st_r;
    sec_cnt_nxt = sec_cnt_r;
    op_nxt = op_r;
    dat_nxt = dat_r;
    ptr_nxt = ptr_r;
    addr_nxt = addr_r;
    left_nxt = left_r;
    we_nxt = 1'b0;
    re_nxt = 1'b0;
    run_nxt = 1'b0;
    rx_take = 1'b0;
    f_ivld = 1'b0;
    f_idata = {2'b00, rx_byte_r}; // R10
    mon_nxt = mon_r;
    byp_nxt = byp_r;
    if (!boot_r) begin
      mon_nxt = high_test_voltage; // R04
      byp_nxt = high_test_voltage && !clock_bypass_select_pin; // R09
      st_nxt = S_SEC;
      sec_cnt_nxt = 4'h0;
    end else if (!mon_r && soft_trap_instruction) begin
      mon_nxt = 1'b1; // R04
      byp_nxt = !clock_bypass_select_pin; // R09
      st_nxt = S_RDY;
    end else if (mon_r && rx_vld_r && rx_brk_r) begin
      f_ivld = 1'b1;
      f_idata = 10'h300; // R13
      if (f_irdy) begin
        rx_take = 1'b1;
        st_nxt = (st_r == S_SEC) ? S_SEC : S_CMD;
      end
    end else if (mon_r) begin
      unique case (st_r)
        S_SEC, S_CMD, S_AH, S_AL, S_DATA: begin
          if (rx_vld_r) begin
            f_ivld = 1'b1; // R10
            if (f_irdy) begin
              rx_take = 1'b1;
              unique case (st_r)
                S_SEC: begin
                  sec_cnt_nxt = sec_cnt_r + 1'b1;
                  if (sec_cnt_r == 4'(SEC_BYTES - 1)) begin // R05
                    st_nxt = S_RDY;
                  end
                end
                S_CMD: begin // R14
                  op_nxt = rx_byte_r;
                  if (rx_byte_r == OP_WRITE || rx_byte_r == OP_READ) begin
                    st_nxt = S_AH;
                  end else if (rx_byte_r == OP_IDX_WRITE) begin
                    st_nxt = S_DATA;
                  end else if (rx_byte_r == OP_IDX_READ) begin
                    left_nxt = 2'd2; // R17
                    st_nxt = S_RQ;
                  end else if (rx_byte_r == OP_SP_READ) begin
                    st_nxt = S_SPH;
                  end else if (rx_byte_r == OP_RUN) begin
                    run_nxt = 1'b1;
                  end
                end
                S_AH: begin
                  ptr_nxt = {rx_byte_r, ptr_r[7:0]}; // R15
                  st_nxt = S_AL;
                end
                S_AL: begin
                  ptr_nxt = {ptr_r[15:8], rx_byte_r};
                  left_nxt = 2'd1;
                  st_nxt = (op_r == OP_WRITE) ? S_DATA : S_PSH;
                  if (op_r != OP_WRITE) begin
                    st_nxt = S_RQ;
                    addr_nxt = {ptr_r[15:8], rx_byte_r};
                  end
                end
                default: begin
                  dat_nxt = rx_byte_r;
                  if (op_r == OP_IDX_WRITE) begin
                    ptr_nxt = ptr_r + 16'h0001;
                  end
                  addr_nxt = (op_r == OP_IDX_WRITE) ? ptr_r + 16'h0001 : ptr_r;
                  st_nxt = S_WR;
                end
              endcase
            end
          end
        end
        S_RDY: begin
          f_ivld = 1'b1;
          f_idata = 10'h200; // R06
          if (f_irdy) begin
            st_nxt = S_CMD;
          end
        end
        S_WR: begin
          we_nxt = !deny; // R15
          st_nxt = S_CMD;
        end
        S_RQ: begin
          if (op_r == OP_IDX_READ) begin
            ptr_nxt = ptr_r + 16'h0001; // R17
            addr_nxt = ptr_r + 16'h0001;
          end
          st_nxt = S_RW;
        end
        S_RW: begin
          re_nxt = 1'b1;
          st_nxt = S_RP;
        end
        S_RP: begin
          st_nxt = S_BRK;
        end
        S_BRK: begin
          dat_nxt = deny ? RESET_BYTE : mem_rdata; // R16
          left_nxt = left_r - 2'd1;
          st_nxt = S_PSH;
        end
        S_PSH: begin
          f_ivld = 1'b1; // R11
          f_idata = {2'b00, dat_r};
          if (f_irdy) begin
            st_nxt = (left_r != 2'd0) ? S_RQ : S_CMD;
          end
        end
        S_SPH, S_SPL: begin
          f_ivld = 1'b1; // R11
          f_idata = {2'b00, (st_r == S_SPH) ? stack_pointer[15:8] : stack_pointer[7:0]};
          if (f_irdy) begin
            st_nxt = (st_r == S_SPH) ? S_SPL : S_CMD;
          end
        end
      endcase
    end
    wd_nxt = !(mon_r && high_test_voltage) && !watchdog_disable_bit; // R08
    rvec_nxt = mon_nxt ? VEC_RESET_MON : VEC_RESET_USER; // R07
    tvec_nxt = mon_nxt ? VEC_TRAP_MON : VEC_TRAP_USER; // R07
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      rx_st_r <= RX_HOLD;
      rx_cnt_r <= '0;
      rx_bit_r <= 4'h0;
      rx_sh_r <= '0;
      rx_vld_r <= 1'b0;
      rx_brk_r <= 1'b0;
      rx_byte_r <= RESET_BYTE;
      tx_st_r <= TX_IDLE;
      tx_cnt_r <= '0;
      tx_bit_r <= 4'h0;
      tx_sh_r <= '1;
      oe_r <= 1'b0;
      st_r <= S_SEC;
      sec_cnt_r <= 4'h0;
      op_r <= RESET_BYTE;
      dat_r <= RESET_BYTE;
      ptr_r <= RESET_ADDR;
      addr_r <= RESET_ADDR;
      left_r <= 2'd0;
      we_r <= 1'b0;
      re_r <= 1'b0;
      run_r <= 1'b0;
      mon_r <= 1'b0;
      byp_r <= 1'b0;
      boot_r <= 1'b0;
      wd_r <= 1'b0;
      rvec_r <= VEC_RESET_USER;
      tvec_r <= VEC_TRAP_USER;
    end else begin
      rx_st_r <= rx_st_nxt;
      rx_cnt_r <= rx_cnt_nxt;
      rx_bit_r <= rx_bit_nxt;
      rx_sh_r <= rx_sh_nxt;
      rx_vld_r <= rx_vld_nxt;
      rx_brk_r <= rx_brk_nxt;
      rx_byte_r <= rx_byte_nxt;
      tx_st_r <= tx_st_nxt;
      tx_cnt_r <= tx_cnt_nxt;
      tx_bit_r <= tx_bit_nxt;
      tx_sh_r <= tx_sh_nxt;
      oe_r <= oe_nxt;
      st_r <= st_nxt;
      sec_cnt_r <= sec_cnt_nxt;
      op_r <= op_nxt;
      dat_r <= dat_nxt;
      ptr_r <= ptr_nxt;
      addr_r <= addr_nxt;
      left_r <= left_nxt;
      we_r <= we_nxt;
      re_r <= re_nxt;
      run_r <= run_nxt;
      mon_r <= mon_nxt;
      byp_r <= byp_nxt;
      boot_r <= 1'b1;
      wd_r <= wd_nxt;
      rvec_r <= rvec_nxt;
      tvec_r <= tvec_nxt;
    end
  end

  assign serial_comm_pin_out = 1'b0;
  assign serial_comm_pin_oe = oe_r;
  assign mem_addr = addr_r;
  assign mem_wdata = dat_r;
  assign mem_we = we_r;
  assign mem_re = re_r;
  assign run_pulse = run_r;
  assign monitor_mode = mon_r;
  assign osc_div_bypass = byp_r;
  assign watchdog_enable = wd_r;
  assign reset_vector_addr = rvec_r; // R07
  assign trap_vector_addr = tvec_r; // R07
endmodule : msc_port

// ### sim/msc_port_sva.sv
`timescale 1ns/100ps
module msc_port_sva #(
  parameter int BAUD_DIV = 16
) (
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic serial_comm_pin_out,
  input wire logic serial_comm_pin_oe,
  input wire logic high_test_voltage,
  input wire logic clock_bypass_select_pin,
  input wire logic watchdog_disable_bit,
  input wire logic read_protect_en,
  input wire logic sec_authorized,
  input wire logic mem_protected,
  input wire logic mem_we,
  input wire logic run_pulse,
  input wire logic monitor_mode,
  input wire logic osc_div_bypass,
  input wire logic watchdog_enable,
  input wire logic [15:0] reset_vector_addr,
  input wire logic [15:0] trap_vector_addr
);
  import msc_pkg::*;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rstn);
  int hi_cnt_r;
  int hi_cnt_nxt;
  // Counts how long the device has been pulling the pin low.
  always_comb begin
    hi_cnt_nxt = serial_comm_pin_oe ? hi_cnt_r + 1 : 0;
  end
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) hi_cnt_r <= 0;
    else hi_cnt_r <= hi_cnt_nxt;
  end
  property p_pin_low;
    serial_comm_pin_out == 1'b0;
  endproperty
  a_pin_low: assert property (p_pin_low) else $error("serial pin driven high");
  property p_vec_rst;
    reset_vector_addr == (monitor_mode ? VEC_RESET_MON : VEC_RESET_USER);
  endproperty
  a_vec_rst: assert property (p_vec_rst) else $error("reset vector wrong");
  property p_vec_trap;
    trap_vector_addr == (monitor_mode ? VEC_TRAP_MON : VEC_TRAP_USER);
  endproperty
  a_vec_trap: assert property (p_vec_trap) else $error("trap vector wrong");
  property p_wd_off;
    (monitor_mode && high_test_voltage) [*3] |-> !watchdog_enable;
  endproperty
  a_wd_off: assert property (p_wd_off) else $error("watchdog on under high voltage");
  property p_wd_cfg;
    (!high_test_voltage && $stable(watchdog_disable_bit)) [*3]
      |-> watchdog_enable == !watchdog_disable_bit;
  endproperty
  a_wd_cfg: assert property (p_wd_cfg) else $error("watchdog ignores config");
  property p_bit_len;
    $fell(serial_comm_pin_oe) |-> hi_cnt_r > 0 && hi_cnt_r % BAUD_DIV == 0;
  endproperty
  a_bit_len: assert property (p_bit_len) else $error("low run not whole bits");
  property p_we_pulse;
    mem_we |=> !mem_we;
  endproperty
  a_we_pulse: assert property (p_we_pulse) else $error("write strobe too long");
  property p_we_prot;
    mem_we |-> !(read_protect_en && !sec_authorized && mem_protected);
  endproperty
  a_we_prot: assert property (p_we_prot) else $error("protected write");
  property p_bypass;
    $rose(monitor_mode) |-> osc_div_bypass == !$past(clock_bypass_select_pin);
  endproperty
  a_bypass: assert property (p_bypass) else $error("divider bypass wrong");
  c_write: cover property (mem_we);
  c_run: cover property (run_pulse);
  c_tx: cover property ($fell(serial_comm_pin_oe));
endmodule : msc_port_sva
bind msc_port msc_port_sva #(.BAUD_DIV(BAUD_DIV)) u_sva (
  .clk_sys(clk_sys), .rstn(rstn), .serial_comm_pin_out(serial_comm_pin_out),
  .serial_comm_pin_oe(serial_comm_pin_oe), .high_test_voltage(high_test_voltage),
  .clock_bypass_select_pin(clock_bypass_select_pin),
  .watchdog_disable_bit(watchdog_disable_bit), .read_protect_en(read_protect_en),
  .sec_authorized(sec_authorized), .mem_protected(mem_protected), .mem_we(mem_we),
  .run_pulse(run_pulse), .monitor_mode(monitor_mode), .osc_div_bypass(osc_div_bypass),
  .watchdog_enable(watchdog_enable), .reset_vector_addr(reset_vector_addr),
  .trap_vector_addr(trap_vector_addr));

// ### sim/msc_host.sv
`timescale 1ns/100ps
module msc_host #(
  parameter int BD = 16
) (
  input wire logic clk_sys,
  input wire logic pin,
  output logic host_oe
);
  initial host_oe = 1'b0;
  // The stop bit of a byte is left to the pull-up once the line is released.
  task automatic tx(input logic [7:0] d, input logic brk);
    logic [9:0] f;
    f = brk ? 10'h000 : {1'b1, d, 1'b0};
    for (int i = 0; i < (brk ? 10 : 9); i++) begin
      host_oe <= ~f[i];
      repeat (BD) @(posedge clk_sys);
    end
    host_oe <= 1'b0;
  endtask : tx
  task automatic rx(output logic [9:0] f, output logic ok);
    int n;
    n = 0;
    f = 10'h3ff;
    @(posedge clk_sys);
    while (pin !== 1'b0 && n < 40 * BD) begin
      @(posedge clk_sys);
      n++;
    end
    ok = (n < 40 * BD);
    repeat (BD / 2) @(posedge clk_sys);
    for (int i = 0; i < 10; i++) begin
      f[i] = pin;
      if (i < 9) repeat (BD) @(posedge clk_sys);
    end
    // The device ignores the pin until its stop bit has run out.
    repeat (BD / 2 + 1) @(posedge clk_sys);
  endtask : rx
endmodule : msc_host

// ### sim/tb.sv
`timescale 1ns/100ps
module tb;
  import msc_pkg::*;
  localparam int BD = 16;
  logic clk_sys, rstn, trap, hv, bypass, wdb, rpe, auth, hoe, oe, pout, we, run, mon, byp, wden;
  logic [15:0] sp, addr, rvec, tvec, a, p;
  logic [7:0] rdata, wdata, d;
  logic pin, re;
  int fails, num_checks, seed, cyc, runs, rds, n;
  logic [23:0] wq[$];
  assign pin = ~(oe | hoe);
  msc_port #(.BAUD_DIV(BD)) dut (
    .clk_sys(clk_sys), .rstn(rstn), .serial_comm_pin_in(pin), .serial_comm_pin_out(pout),
    .serial_comm_pin_oe(oe), .soft_trap_instruction(trap), .high_test_voltage(hv),
    .clock_bypass_select_pin(bypass), .watchdog_disable_bit(wdb), .read_protect_en(rpe),
    .sec_authorized(auth), .mem_protected(addr[15]), .stack_pointer(sp),
    .mem_rdata(rdata), .mem_addr(addr), .mem_wdata(wdata), .mem_we(we), .mem_re(re),
    .run_pulse(run), .monitor_mode(mon), .osc_div_bypass(byp), .watchdog_enable(wden),
    .reset_vector_addr(rvec), .trap_vector_addr(tvec));
  msc_host #(.BD(BD)) host (.clk_sys(clk_sys), .pin(pin), .host_oe(hoe));
  function automatic logic [7:0] pat(input logic [15:0] x);
    return x[7:0] ^ x[15:8] ^ 8'h5a;
  endfunction : pat
  task automatic stop_test;
    $display("checks %0d fails %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : stop_test
  task automatic err(input string m);
    fails++;
    $display("ERROR %0t %s", $time, m);
  endtask : err
  task automatic chkv(input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp) err($sformatf("value %h expected %h", got, exp));
  endtask : chkv
  task automatic chkw;
    num_checks++;
    if (wq.size() == 0 || {addr, wdata} !== wq.pop_front()) err("unexpected write");
  endtask : chkw
  task automatic get(input logic [9:0] exp);
    logic [9:0] f;
    logic ok;
    host.rx(f, ok);
    num_checks++;
    if (ok !== 1'b1 || f !== exp) err($sformatf("frame %h expected %h", f, exp));
  endtask : get
  task automatic xfer(input logic [7:0] b);
    host.tx(b, 1'b0);
    get({1'b1, b, 1'b0});
  endtask : xfer
  task automatic cmd3(input logic [7:0] op, input logic [15:0] x);
    xfer(op);
    xfer(x[15:8]);
    xfer(x[7:0]);
  endtask : cmd3
  initial begin
    clk_sys = 1'b0;
    forever #12.5 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys) begin
    cyc++;
    if (we === 1'b1) chkw();
    if (run === 1'b1) runs++;
    if (re === 1'b1) rds++;
    rdata <= pat(addr);
    if (cyc > 40000) begin
      fails++;
      stop_test();
    end
  end
  initial begin
    seed = 26097;
    rstn = 1'b0;
    trap = 1'b0;
    hv = 1'b1;
    bypass = 1'b0;
    wdb = 1'b0;
    rpe = 1'b1;
    auth = 1'b0;
    sp = 16'h0000;
    repeat (16) @(posedge clk_sys);
    rstn <= 1'b1;
    sp <= 16'($random(seed));
    repeat (3) @(posedge clk_sys);
    chkv({15'h0000, mon}, 16'h0001);
    chkv(rvec, VEC_RESET_MON);
    chkv(tvec, VEC_TRAP_MON);
    chkv({15'h0000, byp}, 16'h0001);
    chkv({15'h0000, wden}, 16'h0000);
    for (int i = 0; i < SEC_BYTES; i++) begin
      xfer((i == 0) ? OP_WRITE : 8'($random(seed)));
    end
    get(10'h000);
    a = {1'b0, 15'($random(seed))};
    p = {1'b1, 15'($random(seed))};
    d = 8'($random(seed));
    wq.push_back({a, d});
    cmd3(OP_WRITE, a);
    xfer(d);
    cmd3(OP_WRITE, p);
    xfer(~d);
    cmd3(8'h41, a);
    get({1'b1, pat(a), 1'b0});
    cmd3(8'h41, p);
    get({1'b1, 8'h00, 1'b0});
    host.tx(8'h00, 1'b1);
    n = 0;
    do begin
      @(posedge clk_sys);
      n++;
    end while (pin === 1'b1 && n < 4 * BD);
    chkv({15'h0000, n >= BD && n <= 3 * BD}, 16'h0001);
    get(10'h000);
    auth <= 1'b1;
    cmd3(8'h41, p);
    get({1'b1, pat(p), 1'b0});
    xfer(8'h42);
    get({1'b1, pat(p + 16'h0001), 1'b0});
    get({1'b1, pat(p + 16'h0002), 1'b0});
    wq.push_back({p + 16'h0003, d});
    xfer(8'h43);
    xfer(d);
    xfer(8'h44);
    get({1'b1, sp[15:8], 1'b0});
    get({1'b1, sp[7:0], 1'b0});
    xfer(8'h45);
    repeat (4) @(posedge clk_sys);
    chkv(16'(runs), 16'h0001);
    chkv(16'(wq.size()), 16'h0000);
    chkv(16'(rds), 16'h0005);
    rstn <= 1'b0;
    hv <= 1'b0;
    repeat (4) @(posedge clk_sys);
    rstn <= 1'b1;
    repeat (3) @(posedge clk_sys);
    chkv({15'h0000, mon}, 16'h0000);
    chkv(rvec, VEC_RESET_USER);
    chkv({15'h0000, wden}, 16'h0001);
    trap <= 1'b1;
    bypass <= 1'b1;
    @(posedge clk_sys);
    trap <= 1'b0;
    get(10'h000);
    chkv({15'h0000, mon}, 16'h0001);
    chkv({15'h0000, byp}, 16'h0000);
    chkv(tvec, VEC_TRAP_MON);
    wdb <= 1'b1;
    repeat (4) @(posedge clk_sys);
    chkv({15'h0000, wden}, 16'h0000);
    stop_test();
  end
endmodule : tb
